// ---- common/mtcp_defines.svh ----
// Register indices, field positions, reset values and timing figures of the MAC table command port
`ifndef MTCP_DEFINES_SVH
`define MTCP_DEFINES_SVH
`define MTCP_IDX_CMD        16'h1800
`define MTCP_IDX_WR_LOW     16'h1801
`define MTCP_IDX_WR_HIGH    16'h1802
`define MTCP_IDX_RD_LOW     16'h1803
`define MTCP_IDX_RD_HIGH    16'h1804
`define MTCP_IDX_STATUS     16'h1805
`define MTCP_CMD_NEXT_BIT   0
`define MTCP_CMD_FIRST_BIT  1
`define MTCP_CMD_MAKE_BIT   2
`define MTCP_CMD_W          3
`define MTCP_STS_PEND_BIT   0
`define MTCP_MAC_HIGH_MSB   15
`define MTCP_AGE0_BIT       23
`define MTCP_STATIC_BIT     24
`define MTCP_AGE1_BIT       25
`define MTCP_VALID_BIT      26
`define MTCP_WR_HIGH_MASK   32'h07FF_FFFF
`define MTCP_RST_WORD       32'h0000_0000
`define MTCP_RST_CMD        3'h0
`define MTCP_AGE_FULL       2'h3
`define MTCP_TABLE_DEPTH    16
`define MTCP_IDX_W          4
`define MTCP_SCAN_MAX       18
`define MTCP_CLK_HZ         40000000
`define MTCP_MS_PER_S       1000
`define MTCP_AGE_TICK_S     150
`endif

// ---- common/mtcp_pkg.sv ----
// Types shared by the MAC table command port
package mtcp_pkg;
  `include "mtcp_defines.svh"

  typedef struct packed {
    logic [17:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mtcp_bus_req_t;

  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
  } mtcp_entry_t;

  typedef enum logic [1:0] {
    MTCP_IDLE,
    MTCP_MAKE,
    MTCP_SCAN
  } mtcp_state_t;
endpackage : mtcp_pkg

// ---- core/mtcp_mac_table_command_port.sv ----
// MAC lookup table with its software command port and aging sweep
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "mtcp_defines.svh"
module mtcp_mac_table_command_port
  import mtcp_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = `MTCP_CLK_HZ / `MTCP_MS_PER_S,
  parameter int unsigned AGE_TICK_MS = `MTCP_AGE_TICK_S * `MTCP_MS_PER_S
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Register port
  input  wire mtcp_bus_req_t busReq,
  output logic [31:0]        rdData,
  // Source address match from the forwarding path
  input  wire logic          saMatchValid,
  input  wire logic [47:0]   saMatchMac,
  // Status
  output logic               opPending
);
  localparam int DEPTH    = `MTCP_TABLE_DEPTH;
  localparam int IW       = `MTCP_IDX_W;
  localparam int SCAN_MAX = `MTCP_SCAN_MAX;

  function automatic logic [47:0] macOf(input mtcp_entry_t e);
    macOf = {e.high[`MTCP_MAC_HIGH_MSB:0], e.low};
  endfunction : macOf

  function automatic logic [1:0] ageOf(input mtcp_entry_t e);
    ageOf = {e.high[`MTCP_AGE1_BIT], e.high[`MTCP_AGE0_BIT]};
  endfunction : ageOf

  function automatic mtcp_entry_t withAge(input mtcp_entry_t e, input logic [1:0] age);
    withAge = e;
    withAge.high[`MTCP_AGE1_BIT] = age[1];
    withAge.high[`MTCP_AGE0_BIT] = age[0];
  endfunction : withAge

  // Lowest set bit of a vector, with a hit flag on top
  function automatic logic [IW:0] firstSet(input logic [DEPTH-1:0] vec);
    firstSet = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        firstSet = {1'b1, IW'(i)};
      end
    end
  endfunction : firstSet

  mtcp_state_t             stateReg;
  logic [`MTCP_CMD_W-1:0]  cmdReg;
  logic [31:0]             wrLowReg;
  logic [31:0]             wrHighReg;
  logic [31:0]             rdLowReg;
  logic [31:0]             rdHighReg;
  logic [31:0]             rdDataReg;
  logic [IW:0]             scanIdxReg;
  logic [IW:0]             nextIdxReg;
  logic [15:0]             msCntReg;
  logic [17:0]             tickCntReg;
  logic                    ageDueReg;
  mtcp_entry_t             tableReg [DEPTH];
  mtcp_entry_t             entryNext [DEPTH];

  // Address decode
  wire [15:0] regIdx     = busReq.addr[17:2];
  wire        aligned    = busReq.addr[1:0] == 2'h0;
  wire        selCmd     = aligned && regIdx == `MTCP_IDX_CMD;
  wire        selWrLow   = aligned && regIdx == `MTCP_IDX_WR_LOW;
  wire        selWrHigh  = aligned && regIdx == `MTCP_IDX_WR_HIGH;
  wire        selRdLow   = aligned && regIdx == `MTCP_IDX_RD_LOW;
  wire        selRdHigh  = aligned && regIdx == `MTCP_IDX_RD_HIGH;
  wire        selStatus  = aligned && regIdx == `MTCP_IDX_STATUS;

  wire [31:0] readMux =
    selCmd    ? {29'h0000_0000, cmdReg} :
    selWrLow  ? wrLowReg :
    selWrHigh ? wrHighReg :
    selRdLow  ? rdLowReg :
    selRdHigh ? rdHighReg :
    selStatus ? {31'h0000_0000, opPending} : `MTCP_RST_WORD;

  // Command acceptance
  wire [`MTCP_CMD_W-1:0] cmdBits = busReq.wdata[`MTCP_CMD_W-1:0];
  wire cmdStart = busReq.wr && selCmd && (|cmdBits) && stateReg == MTCP_IDLE;
  // Several bits at once: entry-write wins, then restart, then advance
  wire startMake  = cmdStart && cmdBits[`MTCP_CMD_MAKE_BIT];
  wire startFirst = cmdStart && !startMake && cmdBits[`MTCP_CMD_FIRST_BIT];

  assign opPending = |cmdReg;

  // Entry-write slot choice: the matching entry if any, else the lowest free slot
  wire mtcp_entry_t stagedEntry = '{high: wrHighReg, low: wrLowReg};
  wire [47:0]       stagedMac   = macOf(stagedEntry);
  wire              stagedValid = wrHighReg[`MTCP_VALID_BIT];
  logic [DEPTH-1:0] makeMatchVec;
  logic [DEPTH-1:0] freeVec;
  logic [DEPTH-1:0] saMatchVec;
  logic [DEPTH-1:0] agingVec;

  for (genvar i = 0; i < DEPTH; i++) begin : g_vec
    wire entValid  = tableReg[i].high[`MTCP_VALID_BIT];
    wire entStatic = tableReg[i].high[`MTCP_STATIC_BIT];
    assign makeMatchVec[i] = entValid && macOf(tableReg[i]) == stagedMac;
    assign freeVec[i]      = !entValid;
    assign saMatchVec[i]   = saMatchValid && entValid && !entStatic && macOf(tableReg[i]) == saMatchMac;
    assign agingVec[i]     = entValid && !entStatic;
  end

  wire [IW:0]   matchRes  = firstSet(makeMatchVec);
  wire [IW:0]   freeRes   = firstSet(freeVec);
  wire          matchHit  = matchRes[IW];
  // A full table drops a new entry; a change to an existing one always lands
  wire          makeWrite = stateReg == MTCP_MAKE && (matchHit || (stagedValid && freeRes[IW]));
  wire [IW-1:0] makeIdx   = matchHit ? matchRes[IW-1:0] : freeRes[IW-1:0];

  // Lookup walk
  wire          scanEnd   = scanIdxReg[IW];
  wire          scanFound = !scanEnd && tableReg[scanIdxReg[IW-1:0]].high[`MTCP_VALID_BIT];
  wire          scanDone  = stateReg == MTCP_SCAN && (scanEnd || scanFound);
  wire          opDone    = stateReg == MTCP_MAKE || scanDone;

  // Aging timebase; the sweep waits for an idle port so a walk never sees entries vanish
  wire msTick    = msCntReg == 16'(MS_CYCLES - 1);
  wire ageTick   = msTick && tickCntReg == 18'(AGE_TICK_MS - 1);
  wire ageStrobe = ageDueReg && stateReg == MTCP_IDLE && !cmdStart;

  for (genvar i = 0; i < DEPTH; i++) begin : g_next
    wire [1:0] age = ageOf(tableReg[i]);
    mtcp_entry_t cleared;
    always_comb begin
      cleared = tableReg[i];
      cleared.high[`MTCP_VALID_BIT] = 1'b0;
    end
    assign entryNext[i] =
      (makeWrite && makeIdx == IW'(i)) ? stagedEntry :
      saMatchVec[i] ? withAge(tableReg[i], `MTCP_AGE_FULL) :
      (ageStrobe && agingVec[i] && age <= 2'h1) ? cleared :
      (ageStrobe && agingVec[i]) ? withAge(tableReg[i], 2'(age - 2'h1)) : tableReg[i];

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        tableReg[i] <= '0;
      end else begin
        tableReg[i] <= entryNext[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmdReg <= `MTCP_RST_CMD;
    end else if (cmdStart) begin
      cmdReg <= cmdBits;
    end else if (opDone) begin
      cmdReg <= `MTCP_RST_CMD;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateReg   <= MTCP_IDLE;
      scanIdxReg <= '0;
    end else begin
      unique case (stateReg)
        MTCP_IDLE: begin
          if (startMake) begin
            stateReg <= MTCP_MAKE;
          end else if (cmdStart) begin
            stateReg   <= MTCP_SCAN;
            scanIdxReg <= startFirst ? '0 : nextIdxReg;
          end
        end
        MTCP_MAKE: begin
          stateReg <= MTCP_IDLE;
        end
        MTCP_SCAN: begin
          if (scanDone) begin
            stateReg <= MTCP_IDLE;
          end else begin
            scanIdxReg <= (IW + 1)'(scanIdxReg + 1'b1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdLowReg   <= `MTCP_RST_WORD;
      rdHighReg  <= `MTCP_RST_WORD;
      nextIdxReg <= '0;
    end else if (scanDone && scanFound) begin
      rdLowReg   <= tableReg[scanIdxReg[IW-1:0]].low;
      rdHighReg  <= tableReg[scanIdxReg[IW-1:0]].high;
      nextIdxReg <= (IW + 1)'(scanIdxReg + 1'b1);
    end else if (scanDone) begin
      rdLowReg   <= `MTCP_RST_WORD;
      rdHighReg  <= `MTCP_RST_WORD;
      nextIdxReg <= scanIdxReg;
    end
  end

  // Staging registers stay writable while busy; software must not touch them mid entry-write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrLowReg  <= `MTCP_RST_WORD;
      wrHighReg <= `MTCP_RST_WORD;
    end else begin
      if (busReq.wr && selWrLow) begin
        wrLowReg <= busReq.wdata;
      end
      if (busReq.wr && selWrHigh) begin
        wrHighReg <= busReq.wdata & `MTCP_WR_HIGH_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdDataReg <= `MTCP_RST_WORD;
    end else begin
      rdDataReg <= busReq.rd ? readMux : `MTCP_RST_WORD;
    end
  end

  assign rdData = rdDataReg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msCntReg   <= '0;
      tickCntReg <= '0;
      ageDueReg  <= 1'b0;
    end else begin
      msCntReg <= msTick ? '0 : 16'(msCntReg + 1'b1);
      if (ageTick) begin
        tickCntReg <= '0;
      end else if (msTick) begin
        tickCntReg <= 18'(tickCntReg + 1'b1);
      end
      if (ageTick) begin
        ageDueReg <= 1'b1;
      end else if (ageStrobe) begin
        ageDueReg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_pend_on_cmd;
    cmdStart |=> opPending && cmdReg == $past(cmdBits);
  endproperty
  a_pend_on_cmd: assert property (p_pend_on_cmd) else $error("pending not raised by command");

  property p_busy_ignore;
    busReq.wr && selCmd && opPending && !opDone |=> cmdReg == $past(cmdReg);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("command changed while busy");

  property p_zero_write;
    busReq.wr && selCmd && cmdBits == 3'h0 && !opPending |=> !opPending;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write started a command");

  property p_make_timing;
    startMake |=> opPending ##1 !opPending;
  endproperty
  a_make_timing: assert property (p_make_timing) else $error("entry-write not two cycles");

  property p_make_store;
    makeWrite |=> tableReg[$past(makeIdx)] == $past(stagedEntry);
  endproperty
  a_make_store: assert property (p_make_store) else $error("entry not stored");

  property p_scan_bound;
    cmdStart && !startMake |-> ##[1:SCAN_MAX] !opPending;
  endproperty
  a_scan_bound: assert property (p_scan_bound) else $error("lookup did not finish");

  property p_found_load;
    stateReg == MTCP_SCAN && scanFound |=> rdHighReg[`MTCP_VALID_BIT] && !opPending
      && rdLowReg == $past(tableReg[scanIdxReg[IW-1:0]].low);
  endproperty
  a_found_load: assert property (p_found_load) else $error("found entry not loaded");

  property p_end_invalid;
    stateReg == MTCP_SCAN && scanEnd |=> !rdHighReg[`MTCP_VALID_BIT] && !opPending;
  endproperty
  a_end_invalid: assert property (p_end_invalid) else $error("end of table left valid data");

  property p_cmd_reserved;
    busReq.rd && selCmd |=> rdData[31:3] == 29'h0000_0000 && rdData[2:0] == $past(cmdReg);
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved) else $error("command readback wrong");

  property p_low_stage;
    busReq.wr && selWrLow |=> wrLowReg == $past(busReq.wdata);
  endproperty
  a_low_stage: assert property (p_low_stage) else $error("low staging not written");

  property p_static_kept;
    ageStrobe && tableReg[0].high[`MTCP_VALID_BIT] && tableReg[0].high[`MTCP_STATIC_BIT]
      |=> tableReg[0] == $past(tableReg[0]);
  endproperty
  a_static_kept: assert property (p_static_kept) else $error("static entry aged");

  // Sweep logic is replicated per slot; slot 1 is watched since slot 0 tends to hold static entries
  property p_age_remove;
    ageStrobe && agingVec[1] && ageOf(tableReg[1]) <= 2'h1 && !saMatchVec[1]
      |=> !tableReg[1].high[`MTCP_VALID_BIT];
  endproperty
  a_age_remove: assert property (p_age_remove) else $error("expired entry kept");

  property p_high_stage;
    busReq.wr && selWrHigh |=> wrHighReg == ($past(busReq.wdata) & `MTCP_WR_HIGH_MASK);
  endproperty
  a_high_stage: assert property (p_high_stage) else $error("high staging not masked");

  property p_status_read;
    busReq.rd && selStatus |=> rdData == {31'h0000_0000, $past(opPending)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status pending readback wrong");

  c_make: cover property (makeWrite && !stagedValid);
  c_first: cover property (startFirst ##[1:SCAN_MAX] (scanDone && scanFound));
  c_end: cover property (scanDone && scanEnd);
  c_age: cover property (ageStrobe && |agingVec);
  c_refresh: cover property (ageStrobe && |saMatchVec);
endmodule : mtcp_mac_table_command_port

// ---- tb/mac_table_command_port_bench.sv ----
// Self-checking bench for the MAC table command port
`timescale 1ns/100ps
`include "mtcp_defines.svh"
module mac_table_command_port_bench
  import mtcp_pkg::*;
;
  logic          clk;
  logic          sys_rst;
  mtcp_bus_req_t busReq;
  logic [31:0]   rdData;
  logic          saMatchValid;
  logic [47:0]   saMatchMac;
  logic          opPending;
  int            n_fail;
  int            total_checks;
  int            seed;
  int            n;
  logic          hit;
  logic [31:0]   v;
  logic [31:0]   h;
  logic [31:0]   lo [5];
  logic [31:0]   hi [5];

  // Short aging figures so a sweep comes every 12 cycles
  mtcp_mac_table_command_port #(
    .MS_CYCLES   (4),
    .AGE_TICK_MS (3)
  ) u_dut (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .busReq       (busReq),
    .rdData       (rdData),
    .saMatchValid (saMatchValid),
    .saMatchMac   (saMatchMac),
    .opPending    (opPending)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One strobe cycle, then idle; leaves a gap before the next request
  task automatic bus(input logic w, input logic r, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{addr: {idx, 2'b00}, wdata: d, wr: w, rd: r};
    @(posedge clk);
    busReq <= '0;
  endtask : bus

  task automatic rd(input logic [15:0] idx, output logic [31:0] val);
    bus(1'b0, 1'b1, idx, 32'h0000_0000);
    @(negedge clk);
    val = rdData;
  endtask : rd

  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (opPending !== 1'b0 && cnt < 40) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 40) begin
      n_fail++;
      test_done();
    end
  endtask : wait_idle

  task automatic cmd(input logic [2:0] bits, output int cnt);
    logic [31:0] c;
    bus(1'b1, 1'b0, `MTCP_IDX_CMD, {29'h0, bits});
    @(negedge clk);
    check({31'h0, opPending}, 32'h0000_0001);
    wait_idle(cnt);
    rd(`MTCP_IDX_CMD, c);
    check(c, 32'h0000_0000);
  endtask : cmd

  task automatic make(input logic [31:0] l, input logic [31:0] hh);
    int k;
    bus(1'b1, 1'b0, `MTCP_IDX_WR_LOW, l);
    bus(1'b1, 1'b0, `MTCP_IDX_WR_HIGH, hh);
    cmd(3'h4, k);
    check(32'(k), 32'h0000_0001);
  endtask : make

  task automatic get(input logic [2:0] bits, output logic [31:0] l, output logic [31:0] hh);
    int k;
    cmd(bits, k);
    rd(`MTCP_IDX_RD_LOW, l);
    rd(`MTCP_IDX_RD_HIGH, hh);
  endtask : get

  // Walks the table from the start and reports whether the address is present
  task automatic find(input logic [47:0] mac, output logic found);
    logic [31:0] l;
    logic [31:0] hh;
    found = 1'b0;
    get(3'h2, l, hh);
    for (int i = 0; i < 17 && hh[`MTCP_VALID_BIT] === 1'b1; i++) begin
      if ({hh[15:0], l} === mac) found = 1'b1;
      get(3'h1, l, hh);
    end
  endtask : find

  initial begin
    seed = 15868;
    n_fail = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    busReq = '0;
    saMatchValid = 1'b0;
    saMatchMac = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, unmapped index, read-only upper command bits
    rd(`MTCP_IDX_CMD, v);
    check(v, 32'h0000_0000);
    rd(`MTCP_IDX_WR_LOW, v);
    check(v, `MTCP_RST_WORD);
    h = $random(seed);
    bus(1'b1, 1'b0, `MTCP_IDX_WR_LOW, h);
    rd(`MTCP_IDX_WR_LOW, v);
    check(v, h);
    rd(16'h1806, v);
    check(v, 32'h0000_0000);
    bus(1'b1, 1'b0, `MTCP_IDX_CMD, 32'hFFFF_FFF8);
    @(negedge clk);
    check({31'h0, opPending}, 32'h0000_0000);
    rd(`MTCP_IDX_CMD, v);
    check(v, 32'h0000_0000);
    bus(1'b1, 1'b0, `MTCP_IDX_WR_HIGH, 32'hFFFF_FFFF);
    rd(`MTCP_IDX_WR_HIGH, v);
    check(v, `MTCP_WR_HIGH_MASK);
    // Random addresses kept distinct by bits 3:1; multicast bit varies
    for (int i = 0; i < 5; i++) begin
      lo[i] = $random(seed);
      lo[i][3:0] = {i[2:0], i[0]};
      hi[i] = ($random(seed) & 32'h0000_FFFF) | (i < 3 ? 32'h0500_0000 : 32'h0680_0000);
    end
    for (int i = 0; i < 3; i++) make(lo[i], hi[i]);
    get(3'h2, v, h);
    check(v, lo[0]);
    check(h, hi[0]);
    for (int i = 1; i < 3; i++) begin
      get(3'h1, v, h);
      check(v, lo[i]);
      check(h, hi[i]);
    end
    // Long scan to table end; a make written meanwhile must be dropped
    bus(1'b1, 1'b0, `MTCP_IDX_WR_LOW, lo[3]);
    bus(1'b1, 1'b0, `MTCP_IDX_WR_HIGH, hi[3] | 32'h0100_0000);
    bus(1'b1, 1'b0, `MTCP_IDX_CMD, 32'h0000_0001);
    bus(1'b1, 1'b0, `MTCP_IDX_CMD, 32'h0000_0004);
    rd(`MTCP_IDX_CMD, v);
    check(v, 32'h0000_0001);
    rd(`MTCP_IDX_STATUS, v);
    check(v, 32'h0000_0001);
    wait_idle(n);
    rd(`MTCP_IDX_RD_HIGH, h);
    check(h & 32'h0400_0000, 32'h0000_0000);
    find({hi[3][15:0], lo[3]}, hit);
    check({31'h0, hit}, 32'h0000_0000);
    // Change one entry, remove another
    make(lo[0], hi[0] ^ 32'h0080_0000);
    get(3'h2, v, h);
    check(h, hi[0] ^ 32'h0080_0000);
    make(lo[1], hi[1] & ~32'h0400_0000);
    find({hi[1][15:0], lo[1]}, hit);
    check({31'h0, hit}, 32'h0000_0000);
    find({hi[2][15:0], lo[2]}, hit);
    check({31'h0, hit}, 32'h0000_0001);
    // Two aging entries; only one sees source matches
    make(lo[3], hi[3]);
    make(lo[4], hi[4]);
    // Refresh stays on through the walks, which span several sweeps
    @(posedge clk);
    saMatchValid <= 1'b1;
    saMatchMac <= {hi[4][15:0], lo[4]};
    repeat (120) @(posedge clk);
    find({hi[3][15:0], lo[3]}, hit);
    check({31'h0, hit}, 32'h0000_0000);
    find({hi[4][15:0], lo[4]}, hit);
    check({31'h0, hit}, 32'h0000_0001);
    find({hi[0][15:0], lo[0]}, hit);
    check({31'h0, hit}, 32'h0000_0001);
    // Refresh stops; the entry must age out within a few sweeps
    @(posedge clk);
    saMatchValid <= 1'b0;
    repeat (60) @(posedge clk);
    find({hi[4][15:0], lo[4]}, hit);
    check({31'h0, hit}, 32'h0000_0000);
    test_done();
  end
endmodule : mac_table_command_port_bench
